/* rtl/thbp_regs.sv */
/*
 * Register bank of the transmit HDLC unit: indirect access to the block
 * pointer memory and the global configuration register, plus the per-byte
 * bit ordering and DMA size limit that the configuration steers.
 * Assumes a host port on clk_in that issues single-cycle read and write
 * strobes with a word address and active-low byte enables.
 */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Select write starts indirect access to block
// - Direction zero writes data register to RAM
// - Direction one reads RAM into data register
// - Busy high from start until access done
// - Word access only; all enables negated ignored
// - Pointer set up in data register first
// - Data register holds write until read completes
// - Burst field plus one limits blocks
// - Enabled limit lets transfers merge per transaction
// - Disabled limit means one block per transaction when the size code is zero
// - Order low sends lane bit zero first
// - Order high sends lane bit seven first
// - Seven-bit mode forces last bit to stuff
// - Configuration applies to every channel alike
// - Transfer size code is blocks minus one
module thbp_regs (
    // Clock and reset.
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    // Host register port.
    input  wire logic [thbp_pkg::ADDR_W-1:0] addr_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    input  wire logic [3:0]                  bus_byte_enables_n_in,
    input  wire logic [31:0]                 wdata_in,
    output var  logic [31:0]                 rdata_out,
    output var  logic                        rvalid_out,
    // Transmit datapath side.
    input  wire logic [3:0]                  channel_transfer_size_in,
    input  wire logic                        seven_bit_mode_in,
    input  wire logic                        byte_valid_in,
    input  wire logic [7:0]                  byte_in,
    output var  logic [4:0]                  dma_max_blocks_out,
    output var  logic                        line_valid_out,
    output var  logic [7:0]                  line_byte_out
);
    typedef enum logic [1:0] {THBP_IDLE, THBP_ACCESS, THBP_FINISH} thbp_st_t;

    thbp_st_t                  state;
    thbp_pkg::thbp_cfg_t       cfg;
    logic                      busy;
    logic                      dir_read;
    logic [thbp_pkg::BLK_W-1:0] block_sel;
    logic [thbp_pkg::BLK_W-1:0] ptr_data;
    logic [thbp_pkg::BLK_W-1:0] ram_rdata;
    logic                      be_any;
    logic                      wr_sel;
    logic                      wr_data;
    logic                      wr_cfg;

    // Mirror a byte so that lane bit zero reaches the first-sent position.
    function automatic logic [7:0] thbp_mirror(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            thbp_mirror[i] = b[7 - i];
        end
    endfunction : thbp_mirror

    // Transfer-size code to block count.
    function automatic logic [4:0] thbp_blocks(input logic [3:0] code);
        thbp_blocks = {1'b0, code} + thbp_pkg::ONE_BLOCK;
    endfunction : thbp_blocks

    assign be_any  = bus_byte_enables_n_in != thbp_pkg::BE_NONE;
    assign wr_sel  = wr_in && be_any && addr_in == thbp_pkg::OFS_BLOCK_SEL;
    assign wr_data = wr_in && be_any && addr_in == thbp_pkg::OFS_BLOCK_DATA;
    assign wr_cfg  = wr_in && be_any && addr_in == thbp_pkg::OFS_CONFIG;

    // A new select write is taken even while busy; polling is left to software.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            block_sel <= '0;
            dir_read  <= 1'b0;
        end else if (wr_sel) begin
            block_sel <= wdata_in[thbp_pkg::BLK_W-1:0];
            dir_read  <= wdata_in[thbp_pkg::SEL_DIR_BIT];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= THBP_IDLE;
            busy  <= 1'b0;
        end else begin
            case (state)
                THBP_IDLE: begin
                    if (wr_sel) begin
                        state <= THBP_ACCESS;
                        busy  <= 1'b1;
                    end
                end
                THBP_ACCESS: begin
                    state <= THBP_FINISH;
                end
                THBP_FINISH: begin
                    state <= THBP_IDLE;
                    busy  <= 1'b0;
                end
                default: begin
                    state <= THBP_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    // The RAM result wins over a host write landing in the same cycle.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ptr_data <= '0;
        end else if (state == THBP_FINISH && dir_read) begin
            ptr_data <= ram_rdata;
        end else if (wr_data) begin
            ptr_data <= wdata_in[thbp_pkg::BLK_W-1:0];
        end
    end

    thbp_ptr_ram u_ram (
        .clk_in    (clk_in),
        .we_in     (state == THBP_ACCESS && !dir_read),
        .re_in     (state == THBP_ACCESS && dir_read),
        .addr_in   (block_sel),
        .wdata_in  (ptr_data),
        .rdata_out (ram_rdata)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cfg <= thbp_pkg::CFG_RESET;
        end else if (wr_cfg) begin
            cfg.lsb_stuff_value       <= wdata_in[thbp_pkg::CFG_STUFF_BIT];
            cfg.msb_first_order       <= wdata_in[thbp_pkg::CFG_ORDER_BIT];
            cfg.dma_size_limit_enable <= wdata_in[thbp_pkg::CFG_LIMIT_BIT];
            cfg.burst <= wdata_in[thbp_pkg::CFG_BURST_LO +: 4];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out  <= thbp_pkg::READ_ZERO;
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= rd_in && be_any;
            rdata_out  <= thbp_pkg::READ_ZERO;
            if (rd_in && be_any) begin
                case (addr_in)
                    thbp_pkg::OFS_BLOCK_SEL: begin
                        rdata_out[thbp_pkg::SEL_BUSY_BIT] <= busy;
                        rdata_out[thbp_pkg::SEL_DIR_BIT]  <= dir_read;
                        rdata_out[thbp_pkg::BLK_W-1:0]    <= block_sel;
                    end
                    thbp_pkg::OFS_BLOCK_DATA: begin
                        rdata_out[thbp_pkg::BLK_W-1:0] <= ptr_data;
                    end
                    thbp_pkg::OFS_CONFIG: begin
                        rdata_out[thbp_pkg::CFG_STUFF_BIT] <=
                            cfg.lsb_stuff_value;
                        rdata_out[thbp_pkg::CFG_ORDER_BIT] <=
                            cfg.msb_first_order;
                        rdata_out[thbp_pkg::CFG_LIMIT_BIT] <=
                            cfg.dma_size_limit_enable;
                        rdata_out[thbp_pkg::CFG_BURST_LO +: 4] <= cfg.burst;
                    end
                    default: begin
                        rdata_out <= thbp_pkg::READ_ZERO;
                    end
                endcase
            end
        end
    end

    // One configuration serves every channel; only the size code varies.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dma_max_blocks_out <= thbp_pkg::ONE_BLOCK;
        end else if (channel_transfer_size_in !=
                     thbp_pkg::XFER_ONE_BLOCK) begin
            dma_max_blocks_out <= thbp_blocks(channel_transfer_size_in);
        end else if (cfg.dma_size_limit_enable) begin
            dma_max_blocks_out <= thbp_blocks(cfg.burst);
        end else begin
            dma_max_blocks_out <= thbp_pkg::ONE_BLOCK;
        end
    end

    // Bit 7 of the line byte leaves first on the link.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            line_valid_out <= 1'b0;
            line_byte_out  <= '0;
        end else begin
            line_valid_out <= byte_valid_in;
            if (byte_valid_in) begin
                line_byte_out <= cfg.msb_first_order ? byte_in
                                 : thbp_mirror(byte_in);
                if (seven_bit_mode_in) begin
                    line_byte_out[0] <= cfg.lsb_stuff_value;
                end
            end
        end
    end

    sequence start_s;
        state == THBP_IDLE && wr_sel;
    endsequence

    busy_rise_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        start_s |=> busy [*2] ##1 !busy)
        else $error("busy does not span the access");
    read_load_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        start_s ##0 wdata_in[thbp_pkg::SEL_DIR_BIT] |=> ##2
        ptr_data == $past(ram_rdata))
        else $error("read result not loaded");
    ram_write_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        start_s ##0 !wdata_in[thbp_pkg::SEL_DIR_BIT] ##1 !wr_data
        |=> u_ram.mem[$past(block_sel)] == $past(ptr_data, 2))
        else $error("pointer not written");
    be_ignore_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        wr_in && bus_byte_enables_n_in == thbp_pkg::BE_NONE && !busy
        |=> $stable(cfg) && $stable(block_sel) && !busy)
        else $error("write with no enables took effect");
    data_hold_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !wr_data && state != THBP_FINISH |=> $stable(ptr_data))
        else $error("data register changed alone");
    limit_off_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        channel_transfer_size_in == thbp_pkg::XFER_ONE_BLOCK
        && !cfg.dma_size_limit_enable && $stable(cfg)
        |=> dma_max_blocks_out == thbp_pkg::ONE_BLOCK)
        else $error("one block limit broken");
    limit_on_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        channel_transfer_size_in == thbp_pkg::XFER_ONE_BLOCK
        && cfg.dma_size_limit_enable && $stable(cfg)
        |=> dma_max_blocks_out == {1'b0, $past(cfg.burst)} + thbp_pkg::ONE_BLOCK)
        else $error("burst limit wrong");
    lsb_first_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        byte_valid_in && !cfg.msb_first_order && !seven_bit_mode_in
        |=> line_byte_out[7] == $past(byte_in[0]))
        else $error("lane bit zero not first");
    msb_first_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        byte_valid_in && cfg.msb_first_order
        |=> line_byte_out[7] == $past(byte_in[7]))
        else $error("lane bit seven not first");
    stuff_bit_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        byte_valid_in && seven_bit_mode_in
        |=> line_byte_out[0] == $past(cfg.lsb_stuff_value))
        else $error("stuff value not forced");
endmodule : thbp_regs
`default_nettype wire

/* rtl/thbp_pkg.sv */
/*
 * Constants and types shared by the transmit HDLC block pointer register bank.
 * Assumes a 32-bit word register port with active-low byte enables.
 */
package thbp_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          BLK_W           = 11;
    localparam int          RAM_DEPTH       = 2048;
    localparam logic [11:0] OFS_BLOCK_SEL   = 12'h3a0;
    localparam logic [11:0] OFS_BLOCK_DATA  = 12'h3a4;
    localparam logic [11:0] OFS_CONFIG      = 12'h3b0;
    localparam int          SEL_BUSY_BIT    = 15;
    localparam int          SEL_DIR_BIT     = 14;
    localparam int          CFG_STUFF_BIT   = 9;
    localparam int          CFG_ORDER_BIT   = 8;
    localparam int          CFG_LIMIT_BIT   = 7;
    localparam int          CFG_BURST_LO    = 0;
    localparam logic [3:0]  BE_NONE         = 4'hf;
    localparam logic [3:0]  XFER_ONE_BLOCK  = 4'h0;
    localparam logic [4:0]  ONE_BLOCK       = 5'h01;
    localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

    typedef struct packed {
        logic       lsb_stuff_value;
        logic       msb_first_order;
        logic       dma_size_limit_enable;
        logic [3:0] burst;
    } thbp_cfg_t;

    localparam thbp_cfg_t CFG_RESET = '0;
endpackage : thbp_pkg

/* rtl/thbp_ptr_ram.sv */
/*
 * Single-port block pointer memory with a registered read port.
 * Assumes one operation per cycle, issued by the indirect access sequencer.
 */
`timescale 1ns/1ns
`default_nettype none
module thbp_ptr_ram (
    // Clock.
    input  wire logic                     clk_in,
    // Access port.
    input  wire logic                     we_in,
    input  wire logic                     re_in,
    input  wire logic [thbp_pkg::BLK_W-1:0] addr_in,
    input  wire logic [thbp_pkg::BLK_W-1:0] wdata_in,
    output var  logic [thbp_pkg::BLK_W-1:0] rdata_out
);
    logic [thbp_pkg::BLK_W-1:0] mem [thbp_pkg::RAM_DEPTH];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (re_in) begin
            rdata_out <= mem[addr_in];
        end
    end
endmodule : thbp_ptr_ram
`default_nettype wire

/* verification/thbp_regs_tb_top.sv */
/*
 * Self-checking bench for the block pointer register bank and its datapath.
 * Assumes thbp_pkg and thbp_regs are compiled first; the bench drives all
 * ports itself, 1 ns after each rising edge.
 */
`timescale 1ns/1ns
`default_nettype none
module thbp_regs_tb_top;
    logic        clk;
    logic        rst;
    logic [11:0] addr;
    logic        wr;
    logic        rd;
    logic [3:0]  be_n;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        rvalid;
    logic [3:0]  xfer;
    logic        seven;
    logic        bvalid;
    logic [7:0]  bdata;
    logic [4:0]  max_blk;
    logic        lvalid;
    logic [7:0]  lbyte;
    int          fails;
    int          comparisons;
    int          cycles;

    thbp_regs uut (
        .clk_in                   (clk),
        .rst_in                   (rst),
        .addr_in                  (addr),
        .wr_in                    (wr),
        .rd_in                    (rd),
        .bus_byte_enables_n_in    (be_n),
        .wdata_in                 (wdata),
        .rdata_out                (rdata),
        .rvalid_out               (rvalid),
        .channel_transfer_size_in (xfer),
        .seven_bit_mode_in        (seven),
        .byte_valid_in            (bvalid),
        .byte_in                  (bdata),
        .dma_max_blocks_out       (max_blk),
        .line_valid_out           (lvalid),
        .line_byte_out            (lbyte)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // The limit is far above the fewer than 200 cycles the scenarios need.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    // Without the idle cycle a read can follow in the first busy cycle.
    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] be = 4'h0, input bit gap = 1'b1);
        addr = a;
        wdata = d;
        be_n = be;
        wr = 1'b1;
        step();
        wr = 1'b0;
        if (gap) step();
    endtask : bus_wr

    task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
        addr = a;
        be_n = 4'h0;
        rd = 1'b1;
        step();
        rd = 1'b0;
        d = rdata;
        chk({31'h0, rvalid}, 32'h1);
        step();
    endtask : bus_rd

    task automatic wait_idle();
        logic [31:0] v;
        repeat (20) begin
            bus_rd(thbp_pkg::OFS_BLOCK_SEL, v);
            if (v[15] === 1'b0) break;
        end
        chk({31'h0, v[15]}, 32'h0);
    endtask : wait_idle

    task automatic t_reset();
        logic [31:0] v;
        bus_rd(thbp_pkg::OFS_BLOCK_SEL, v);
        chk(v, 32'h0);
        bus_rd(thbp_pkg::OFS_BLOCK_DATA, v);
        chk(v, 32'h0);
        bus_rd(thbp_pkg::OFS_CONFIG, v);
        chk(v, 32'h0);
        bus_rd(12'h3a8, v);
        chk(v, 32'h0);
        chk({27'h0, max_blk}, 32'h1);
    endtask : t_reset

    task automatic t_indirect();
        logic [31:0] v;
        // Partial enables still write the whole word; unused bits read 0.
        // Reserved bits are written as ones here, so the bench breaks the software rules.
        bus_wr(thbp_pkg::OFS_BLOCK_DATA, 32'hffff_7155, 4'he);
        bus_wr(thbp_pkg::OFS_BLOCK_SEL, 32'h0000_07ff, 4'h0, 1'b0);
        bus_rd(thbp_pkg::OFS_BLOCK_SEL, v);
        chk(v, 32'h0000_87ff);
        wait_idle();
        bus_wr(thbp_pkg::OFS_BLOCK_DATA, 32'h0000_02aa);
        bus_wr(thbp_pkg::OFS_BLOCK_SEL, 32'h0000_0001);
        wait_idle();
        bus_wr(thbp_pkg::OFS_BLOCK_DATA, 32'h0000_0333);
        bus_wr(thbp_pkg::OFS_BLOCK_SEL, 32'h0000_47ff, 4'h0, 1'b0);
        bus_rd(thbp_pkg::OFS_BLOCK_DATA, v);
        chk(v, 32'h0000_0333);
        wait_idle();
        bus_rd(thbp_pkg::OFS_BLOCK_DATA, v);
        chk(v, 32'h0000_0155);
        bus_wr(thbp_pkg::OFS_BLOCK_SEL, 32'h0000_4001);
        wait_idle();
        bus_rd(thbp_pkg::OFS_BLOCK_DATA, v);
        chk(v, 32'h0000_02aa);
    endtask : t_indirect

    task automatic t_dma();
        logic [3:0]  xf [6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h3, 4'hf};
        logic [31:0] cf [6] = '{32'h00f, 32'h08f, 32'h080, 32'h085,
                                32'h08f, 32'h000};
        logic [31:0] ex [6] = '{32'h01, 32'h10, 32'h01, 32'h06,
                                32'h04, 32'h10};
        logic [31:0] v;
        bus_wr(thbp_pkg::OFS_CONFIG, 32'h0000_03ff, 4'hf);
        bus_rd(thbp_pkg::OFS_CONFIG, v);
        chk(v, 32'h0);
        for (int i = 0; i < 6; i++) begin
            xfer = xf[i];
            bus_wr(thbp_pkg::OFS_CONFIG, cf[i], 4'h7);
            step();
            chk({27'h0, max_blk}, ex[i]);
        end
        bus_rd(thbp_pkg::OFS_CONFIG, v);
        chk(v, 32'h0);
        xfer = 4'h0;
    endtask : t_dma

    task automatic t_line();
        logic [7:0] e;
        for (int m = 0; m < 8; m++) begin
            seven = m[2];
            bus_wr(thbp_pkg::OFS_CONFIG, {22'h0, m[1], m[0], 8'h0});
            bdata = 8'h1d;
            bvalid = 1'b1;
            step();
            bvalid = 1'b0;
            e = m[0] ? 8'h1d : 8'hb8;
            if (m[2]) e[0] = m[1];
            chk({31'h0, lvalid}, 32'h1);
            chk({24'h0, lbyte}, {24'h0, e});
            step();
            chk({31'h0, lvalid}, 32'h0);
        end
    endtask : t_line

    // A three-block ring: every pointer is rewritten, then read back.
    task automatic t_ring();
        logic [31:0] v;
        for (int b = 0; b < 3; b++) begin
            bus_wr(thbp_pkg::OFS_BLOCK_DATA, 32'h10 + (b + 1) % 3);
            bus_wr(thbp_pkg::OFS_BLOCK_SEL, 32'h10 + b);
            wait_idle();
        end
        for (int b = 0; b < 3; b++) begin
            bus_wr(thbp_pkg::OFS_BLOCK_SEL, 32'h4010 + b);
            wait_idle();
            bus_rd(thbp_pkg::OFS_BLOCK_DATA, v);
            chk(v, 32'h10 + (b + 1) % 3);
        end
    endtask : t_ring

    initial begin
        fails = 0;
        comparisons = 0;
        cycles = 0;
        rst = 1'b1;
        addr = 12'h0;
        wr = 1'b0;
        rd = 1'b0;
        be_n = 4'hf;
        wdata = 32'h0;
        xfer = 4'h0;
        seven = 1'b0;
        bvalid = 1'b0;
        bdata = 8'h0;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_indirect();
        t_dma();
        t_line();
        t_ring();
        end_of_test();
    end
endmodule : thbp_regs_tb_top
`default_nettype wire
